// ### inc/swh_params.svh
// Purpose: constants for the single-wire host port link
// Assumes: 50 MHz system clock
// Notes: times kept in their own units, cycle counts derived
`ifndef SWH_PARAMS_SVH
`define SWH_PARAMS_SVH
`define SWH_CLK_HZ 50000000
`define SWH_BAUD 9600
`define SWH_TICKS_PER_BIT 16
// one tick enable period in clock cycles (rounded down)
`define SWH_TICK_DIV (`SWH_CLK_HZ / (`SWH_BAUD * `SWH_TICKS_PER_BIT))
`define SWH_FIRST_CENTRE_TICKS (24 - 2)
`define SWH_FRAME_BITS 10
// ticks from the stop-bit sample to the end of the frame
`define SWH_STOP_TAIL_TICKS (`SWH_FRAME_BITS * `SWH_TICKS_PER_BIT - `SWH_FIRST_CENTRE_TICKS - 8 * `SWH_TICKS_PER_BIT)
`define SWH_CMD_FLAG_BIT 7
`define SWH_ACK_BIT 6
`define SWH_RSVD_BIT 5
// max response latency 3.125 ms, in microseconds
`define SWH_MAX_RSP_US 3125
`define SWH_MAX_RSP_CYC ((`SWH_MAX_RSP_US * (`SWH_CLK_HZ / 1000000)))
// missing second byte time-out 5 ms, in microseconds
`define SWH_DATA_TMO_US 5000
`define SWH_DATA_TMO_CYC ((`SWH_DATA_TMO_US * (`SWH_CLK_HZ / 1000000)))
// host back-off after contention: three frames of 16 ticks per bit
`define SWH_BACKOFF_TICKS (3 * `SWH_FRAME_BITS * `SWH_TICKS_PER_BIT)
`endif

// ### inc/swh_pkg.sv
// Purpose: shared types for the single-wire host port
// Assumes: constants live in swh_params.svh
// Notes: types only
package swh_pkg;
	typedef enum logic [1:0] {
		SWH_RX_IDLE = 2'b00,
		SWH_RX_SHIFT = 2'b01,
		SWH_RX_WAIT_HIGH = 2'b11
	} swh_rx_state_t;
	typedef enum logic [1:0] {
		SWH_TX_IDLE = 2'b00,
		SWH_TX_SEND = 2'b01,
		SWH_TX_BACKOFF = 2'b11
	} swh_tx_state_t;
endpackage : swh_pkg

// ### inc/swh_link_if.sv
// Purpose: shared open-drain wire joining device and host ends
// Assumes: external pull-up holds the line high when released
// Notes: wired-and of both ends: either pull-down enable takes the line low
`timescale 1ns/1ps
`default_nettype none
interface swh_link_if;
	logic dev_line_oe; // device pulls low when high
	logic host_line_oe; // host pulls low when high
	logic line_level; // resolved wire level
	// pull-up wins unless a party pulls low
	assign line_level = ~(dev_line_oe | host_line_oe);
	modport dev (output dev_line_oe, input line_level);
	modport host (output host_line_oe, input line_level);
endinterface : swh_link_if
`default_nettype wire

// ### hw/swh_host_end.sv
// Purpose: host end of the single-wire port, frame sender and receiver
// Assumes: one clk_sys domain, line passes a two-flop synchroniser
// Notes: reads back the line to catch contention, then backs off
`timescale 1ns/1ps
`default_nettype none
`include "swh_params.svh"
module swh_host_end (
	input wire logic clk_sys, // system clock
	input wire logic rstn, // synchronous reset, active low
	swh_link_if.host link, // shared wire
	input wire logic tx_valid, // byte to send
	input wire logic [7:0] tx_data, // byte value
	output logic tx_ready, // sender idle
	output logic tx_collision, // one-cycle contention pulse
	output logic rx_valid, // one-cycle byte pulse
	output logic [7:0] rx_data // received byte
);
	logic [15:0] div_ff, nxt_div;
	logic tick;
	logic sync1_ff, sync2_ff;
	swh_pkg::swh_tx_state_t tst_ff, nxt_tst;
	logic [8:0] tsh_ff, nxt_tsh;
	logic [3:0] tbit_ff, nxt_tbit;
	logic [8:0] ttk_ff, nxt_ttk;
	logic oe_ff, nxt_oe;
	logic rdy_ff, nxt_rdy;
	logic col_ff, nxt_col;
	swh_pkg::swh_rx_state_t rst_ff, nxt_rst;
	logic prev_ff, nxt_prev;
	logic [4:0] rtk_ff, nxt_rtk;
	logic [3:0] rbit_ff, nxt_rbit;
	logic [7:0] rsh_ff, nxt_rsh;
	logic rv_ff, nxt_rv;
	logic [7:0] rd_ff, nxt_rd;
	// ----------------------------------------
	// tick divider and line synchroniser
	// ----------------------------------------
	assign tick = (div_ff == 16'(`SWH_TICK_DIV - 1));
	always_comb begin
		nxt_div = tick ? 16'h0000 : div_ff + 16'h0001;
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			div_ff <= 16'h0000;
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
		end else begin
			div_ff <= nxt_div;
			sync1_ff <= link.line_level;
			sync2_ff <= sync1_ff;
		end
	end
	// ----------------------------------------
	// sender with contention read-back
	// ----------------------------------------
	always_comb begin
		nxt_tst = tst_ff;
		nxt_tsh = tsh_ff;
		nxt_tbit = tbit_ff;
		nxt_ttk = ttk_ff;
		nxt_oe = oe_ff;
		nxt_col = 1'b0;
		case (tst_ff)
			swh_pkg::SWH_TX_IDLE: begin
				nxt_oe = 1'b0;
				// no start while a frame is on the line; launch on a tick so the start bit is a full bit
				if (tick && tx_valid && rst_ff == swh_pkg::SWH_RX_IDLE && sync2_ff) begin
					nxt_tsh = {tx_data, 1'b0};
					nxt_tbit = 4'h0;
					nxt_ttk = 9'h000;
					nxt_oe = 1'b1;
					nxt_tst = swh_pkg::SWH_TX_SEND;
				end
			end
			swh_pkg::SWH_TX_SEND: begin
				if (tick) begin
					// mid-bit check: released but line low means someone else
					if (ttk_ff == 9'h008 && !oe_ff && !sync2_ff) begin
						nxt_oe = 1'b0;
						nxt_col = 1'b1;
						nxt_ttk = 9'h000;
						nxt_tst = swh_pkg::SWH_TX_BACKOFF;
					end else if (ttk_ff == 9'(`SWH_TICKS_PER_BIT - 1)) begin
						nxt_ttk = 9'h000;
						if (tbit_ff == 4'(`SWH_FRAME_BITS - 1)) begin
							nxt_oe = 1'b0;
							nxt_tst = swh_pkg::SWH_TX_IDLE;
						end else begin
							nxt_tbit = tbit_ff + 4'h1;
							nxt_tsh = {1'b1, tsh_ff[8:1]};
							// stop bit is a release, as is a data one
							nxt_oe = (tbit_ff == 4'(`SWH_FRAME_BITS - 2)) ? 1'b0 : ~tsh_ff[1];
						end
					end else begin
						nxt_ttk = ttk_ff + 9'h001;
					end
				end
			end
			swh_pkg::SWH_TX_BACKOFF: begin
				nxt_oe = 1'b0;
				if (tick) begin
					if (ttk_ff == 9'(`SWH_BACKOFF_TICKS - 1)) begin
						nxt_tst = swh_pkg::SWH_TX_IDLE;
					end else begin
						nxt_ttk = ttk_ff + 9'h001;
					end
				end
			end
			default: begin
				nxt_oe = 1'b0;
				nxt_tst = swh_pkg::SWH_TX_IDLE;
			end
		endcase
		nxt_rdy = (nxt_tst == swh_pkg::SWH_TX_IDLE);
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			tst_ff <= swh_pkg::SWH_TX_IDLE;
			tsh_ff <= 9'h1ff;
			tbit_ff <= 4'h0;
			ttk_ff <= 9'h000;
			oe_ff <= 1'b0;
			rdy_ff <= 1'b0;
			col_ff <= 1'b0;
		end else begin
			tst_ff <= nxt_tst;
			tsh_ff <= nxt_tsh;
			tbit_ff <= nxt_tbit;
			ttk_ff <= nxt_ttk;
			oe_ff <= nxt_oe;
			rdy_ff <= nxt_rdy;
			col_ff <= nxt_col;
		end
	end
	assign link.host_line_oe = oe_ff;
	assign tx_ready = rdy_ff;
	assign tx_collision = col_ff;
	// ----------------------------------------
	// receiver for device frames
	// ----------------------------------------
	always_comb begin
		nxt_rst = rst_ff;
		nxt_prev = sync2_ff;
		nxt_rtk = rtk_ff;
		nxt_rbit = rbit_ff;
		nxt_rsh = rsh_ff;
		nxt_rv = 1'b0;
		nxt_rd = rd_ff;
		case (rst_ff)
			swh_pkg::SWH_RX_IDLE: begin
				// own frames are not received
				if (prev_ff && !sync2_ff && tst_ff != swh_pkg::SWH_TX_SEND) begin
					nxt_rtk = 5'(`SWH_FIRST_CENTRE_TICKS);
					nxt_rbit = 4'h0;
					nxt_rst = swh_pkg::SWH_RX_SHIFT;
				end
			end
			swh_pkg::SWH_RX_SHIFT: begin
				if (tick) begin
					if (rtk_ff == 5'h01) begin
						nxt_rtk = 5'(`SWH_TICKS_PER_BIT);
						if (rbit_ff == 4'h9) begin
							// stop bit over: the wire is free again
							nxt_rst = swh_pkg::SWH_RX_IDLE;
						end else if (rbit_ff == 4'h8) begin
							// stay busy to the end of the stop bit, so no send starts inside it
							nxt_rst = sync2_ff ? swh_pkg::SWH_RX_SHIFT : swh_pkg::SWH_RX_WAIT_HIGH;
							nxt_rtk = 5'(`SWH_STOP_TAIL_TICKS);
							nxt_rbit = 4'h9;
							nxt_rv = sync2_ff;
							nxt_rd = rsh_ff;
						end else begin
							nxt_rsh = {sync2_ff, rsh_ff[7:1]};
							nxt_rbit = rbit_ff + 4'h1;
						end
					end else begin
						nxt_rtk = rtk_ff - 5'h01;
					end
				end
			end
			swh_pkg::SWH_RX_WAIT_HIGH: begin
				if (sync2_ff) begin
					nxt_rst = swh_pkg::SWH_RX_IDLE;
				end
			end
			default: begin
				nxt_rst = swh_pkg::SWH_RX_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rst_ff <= swh_pkg::SWH_RX_IDLE;
			prev_ff <= 1'b1;
			rtk_ff <= 5'h00;
			rbit_ff <= 4'h0;
			rsh_ff <= 8'h00;
			rv_ff <= 1'b0;
			rd_ff <= 8'h00;
		end else begin
			rst_ff <= nxt_rst;
			prev_ff <= nxt_prev;
			rtk_ff <= nxt_rtk;
			rbit_ff <= nxt_rbit;
			rsh_ff <= nxt_rsh;
			rv_ff <= nxt_rv;
			rd_ff <= nxt_rd;
		end
	end
	assign rx_valid = rv_ff;
	assign rx_data = rd_ff;
endmodule : swh_host_end
`default_nettype wire

// ### hw/swh_device_end.sv
// Purpose: device end of the single-wire port with command handling
// Assumes: one clk_sys domain, line and enable pins are synchronised
// Notes: command decode beyond ack/nack is left to the user side
`timescale 1ns/1ps
`default_nettype none
`include "swh_params.svh"
module swh_device_end #(
	parameter int unsigned RSP_MAX_CYC = `SWH_MAX_RSP_CYC, // response latency bound
	parameter int unsigned DATA_TMO_CYC = `SWH_DATA_TMO_CYC // second byte time-out
) (
	input wire logic clk_sys, // system clock
	input wire logic rstn, // synchronous reset, active low
	swh_link_if.dev link, // shared wire
	input wire logic chip_en, // chip-enable pin, async
	input wire logic [31:0] two_byte_map, // commands that take a data byte
	input wire logic [31:0] supported_map, // commands that get ack
	input wire logic status_event, // one-cycle internal status change
	input wire logic [7:0] status_msg, // unsolicited byte to send
	input wire logic mode_req, // pending standby or sleep change
	output logic mode_go, // change may proceed now
	output logic cmd_valid, // one-cycle accepted command pulse
	output logic [7:0] cmd_byte, // command byte
	output logic [7:0] cmd_data, // data byte, if any
	output logic frame_err // one-cycle framing error pulse
);
	logic [15:0] div_ff, nxt_div;
	logic tick;
	logic sync1_ff, sync2_ff, ce1_ff, ce2_ff;
	// receiver
	swh_pkg::swh_rx_state_t rst_ff, nxt_rst;
	logic prev_ff, nxt_prev;
	logic [4:0] rtk_ff, nxt_rtk;
	logic [3:0] rbit_ff, nxt_rbit;
	logic [7:0] rsh_ff, nxt_rsh;
	logic got_ff, nxt_got;
	logic fe_ff, nxt_fe;
	// message layer
	logic wait_data_ff, nxt_wait_data;
	logic [7:0] cb_ff, nxt_cb;
	logic [7:0] cd_ff, nxt_cd;
	logic cv_ff, nxt_cv;
	logic [22:0] tmo_ff, nxt_tmo;
	logic rsp_pend_ff, nxt_rsp_pend;
	logic [7:0] rsp_ff, nxt_rsp;
	logic st_pend_ff, nxt_st_pend;
	logic [7:0] st_ff, nxt_st;
	logic go_ff, nxt_go;
	// sender
	swh_pkg::swh_tx_state_t tst_ff, nxt_tst;
	logic [8:0] tsh_ff, nxt_tsh;
	logic [3:0] tbit_ff, nxt_tbit;
	logic [4:0] ttk_ff, nxt_ttk;
	logic oe_ff, nxt_oe;
	logic start_rsp, start_st, line_busy;
	// ----------------------------------------
	// tick divider and synchronisers
	// ----------------------------------------
	assign tick = (div_ff == 16'(`SWH_TICK_DIV - 1));
	always_comb begin
		nxt_div = tick ? 16'h0000 : div_ff + 16'h0001;
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			div_ff <= 16'h0000;
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
			ce1_ff <= 1'b0;
			ce2_ff <= 1'b0;
		end else begin
			div_ff <= nxt_div;
			sync1_ff <= link.line_level;
			sync2_ff <= sync1_ff;
			ce1_ff <= chip_en;
			ce2_ff <= ce1_ff;
		end
	end
	// ----------------------------------------
	// receiver: edge, centre sampling, stop check
	// ----------------------------------------
	always_comb begin
		nxt_rst = rst_ff;
		nxt_prev = sync2_ff;
		nxt_rtk = rtk_ff;
		nxt_rbit = rbit_ff;
		nxt_rsh = rsh_ff;
		nxt_got = 1'b0;
		nxt_fe = 1'b0;
		case (rst_ff)
			swh_pkg::SWH_RX_IDLE: begin
				// own frames are ignored; host is half-duplex too
				if (prev_ff && !sync2_ff && tst_ff != swh_pkg::SWH_TX_SEND) begin
					nxt_rtk = 5'(`SWH_FIRST_CENTRE_TICKS);
					nxt_rbit = 4'h0;
					nxt_rst = swh_pkg::SWH_RX_SHIFT;
				end
			end
			swh_pkg::SWH_RX_SHIFT: begin
				if (tick) begin
					if (rtk_ff == 5'h01) begin
						nxt_rtk = 5'(`SWH_TICKS_PER_BIT);
						if (rbit_ff == 4'h9) begin
							// stop bit over: the wire is free again
							nxt_rst = swh_pkg::SWH_RX_IDLE;
						end else if (rbit_ff == 4'h8) begin
							// low stop bit: drop byte, wait for release; else stay busy to frame end
							nxt_rst = sync2_ff ? swh_pkg::SWH_RX_SHIFT : swh_pkg::SWH_RX_WAIT_HIGH;
							nxt_rtk = 5'(`SWH_STOP_TAIL_TICKS);
							nxt_rbit = 4'h9;
							nxt_got = sync2_ff;
							nxt_fe = ~sync2_ff;
						end else begin
							nxt_rsh = {sync2_ff, rsh_ff[7:1]};
							nxt_rbit = rbit_ff + 4'h1;
						end
					end else begin
						nxt_rtk = rtk_ff - 5'h01;
					end
				end
			end
			swh_pkg::SWH_RX_WAIT_HIGH: begin
				if (sync2_ff) begin
					nxt_rst = swh_pkg::SWH_RX_IDLE;
				end
			end
			default: begin
				nxt_rst = swh_pkg::SWH_RX_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rst_ff <= swh_pkg::SWH_RX_IDLE;
			prev_ff <= 1'b1;
			rtk_ff <= 5'h00;
			rbit_ff <= 4'h0;
			rsh_ff <= 8'h00;
			got_ff <= 1'b0;
			fe_ff <= 1'b0;
		end else begin
			rst_ff <= nxt_rst;
			prev_ff <= nxt_prev;
			rtk_ff <= nxt_rtk;
			rbit_ff <= nxt_rbit;
			rsh_ff <= nxt_rsh;
			got_ff <= nxt_got;
			fe_ff <= nxt_fe;
		end
	end
	// ----------------------------------------
	// message layer: decode, time-out, replies
	// ----------------------------------------
	assign line_busy = (rst_ff != swh_pkg::SWH_RX_IDLE) || (tst_ff != swh_pkg::SWH_TX_IDLE);
	// launch on a tick so the start bit lasts a full 16 ticks; costs at most one tick of latency
	assign start_rsp = rsp_pend_ff && !line_busy && !got_ff && tick;
	assign start_st = st_pend_ff && !rsp_pend_ff && !line_busy && !got_ff && ce2_ff && tick;
	always_comb begin
		nxt_wait_data = wait_data_ff;
		nxt_cb = cb_ff;
		nxt_cd = cd_ff;
		nxt_cv = 1'b0;
		nxt_tmo = tmo_ff;
		nxt_rsp_pend = start_rsp ? 1'b0 : rsp_pend_ff;
		nxt_rsp = rsp_ff;
		nxt_st_pend = start_st ? 1'b0 : st_pend_ff;
		nxt_st = st_ff;
		// hold mode changes while any frame runs
		nxt_go = mode_req && !line_busy && !wait_data_ff && !rsp_pend_ff;
		if (wait_data_ff) begin
			if (got_ff) begin
				nxt_wait_data = 1'b0;
				nxt_cd = rsh_ff;
				nxt_cv = 1'b1;
				nxt_rsp = {1'b0, 1'b1, cb_ff[5:0]};
				nxt_rsp_pend = 1'b1;
			end else if (tmo_ff == 23'h00_0000) begin
				nxt_wait_data = 1'b0;
				nxt_rsp = {1'b0, 1'b0, cb_ff[5:0]};
				nxt_rsp_pend = 1'b1;
			end else begin
				nxt_tmo = tmo_ff - 23'h00_0001;
			end
		end else if (got_ff) begin
			nxt_cb = rsh_ff;
			// bad flag, reserved bits or unknown code: nack
			if (!rsh_ff[`SWH_CMD_FLAG_BIT] || rsh_ff[`SWH_ACK_BIT] || rsh_ff[`SWH_RSVD_BIT]
					|| !supported_map[rsh_ff[4:0]]) begin
				nxt_rsp = {1'b0, 1'b0, rsh_ff[5:0]};
				nxt_rsp_pend = 1'b1;
			end else if (two_byte_map[rsh_ff[4:0]]) begin
				nxt_wait_data = 1'b1;
				nxt_tmo = 23'(DATA_TMO_CYC - 1);
			end else begin
				nxt_cv = 1'b1;
				nxt_rsp = {1'b0, 1'b1, rsh_ff[5:0]};
				nxt_rsp_pend = 1'b1;
			end
		end
		// a new event wins over the send that clears the flag
		if (status_event) begin
			nxt_st_pend = 1'b1;
			nxt_st = status_msg;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			wait_data_ff <= 1'b0;
			cb_ff <= 8'h00;
			cd_ff <= 8'h00;
			cv_ff <= 1'b0;
			tmo_ff <= 23'h00_0000;
			rsp_pend_ff <= 1'b0;
			rsp_ff <= 8'h00;
			st_pend_ff <= 1'b0;
			st_ff <= 8'h00;
			go_ff <= 1'b0;
		end else begin
			wait_data_ff <= nxt_wait_data;
			cb_ff <= nxt_cb;
			cd_ff <= nxt_cd;
			cv_ff <= nxt_cv;
			tmo_ff <= nxt_tmo;
			rsp_pend_ff <= nxt_rsp_pend;
			rsp_ff <= nxt_rsp;
			st_pend_ff <= nxt_st_pend;
			st_ff <= nxt_st;
			go_ff <= nxt_go;
		end
	end
	// ----------------------------------------
	// sender: reply starts within one tick of the line going free, far inside the bound, save a time-out nack, due 5 ms after the command
	// ----------------------------------------
	always_comb begin
		nxt_tst = tst_ff;
		nxt_tsh = tsh_ff;
		nxt_tbit = tbit_ff;
		nxt_ttk = ttk_ff;
		nxt_oe = oe_ff;
		case (tst_ff)
			swh_pkg::SWH_TX_IDLE: begin
				nxt_oe = 1'b0;
				if (start_rsp || start_st) begin
					nxt_tsh = {start_rsp ? rsp_ff : st_ff, 1'b0};
					nxt_tbit = 4'h0;
					nxt_ttk = 5'h00;
					nxt_oe = 1'b1;
					nxt_tst = swh_pkg::SWH_TX_SEND;
				end
			end
			swh_pkg::SWH_TX_SEND: begin
				if (tick) begin
					if (ttk_ff == 5'(`SWH_TICKS_PER_BIT - 1)) begin
						nxt_ttk = 5'h00;
						if (tbit_ff == 4'(`SWH_FRAME_BITS - 1)) begin
							nxt_oe = 1'b0;
							nxt_tst = swh_pkg::SWH_TX_IDLE;
						end else begin
							nxt_tbit = tbit_ff + 4'h1;
							nxt_tsh = {1'b1, tsh_ff[8:1]};
							nxt_oe = (tbit_ff == 4'(`SWH_FRAME_BITS - 2)) ? 1'b0 : ~tsh_ff[1];
						end
					end else begin
						nxt_ttk = ttk_ff + 5'h01;
					end
				end
			end
			default: begin
				nxt_oe = 1'b0;
				nxt_tst = swh_pkg::SWH_TX_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			tst_ff <= swh_pkg::SWH_TX_IDLE;
			tsh_ff <= 9'h1ff;
			tbit_ff <= 4'h0;
			ttk_ff <= 5'h00;
			oe_ff <= 1'b0;
		end else begin
			tst_ff <= nxt_tst;
			tsh_ff <= nxt_tsh;
			tbit_ff <= nxt_tbit;
			ttk_ff <= nxt_ttk;
			oe_ff <= nxt_oe;
		end
	end
	assign link.dev_line_oe = oe_ff;
	assign mode_go = go_ff;
	assign cmd_valid = cv_ff;
	assign cmd_byte = cb_ff;
	assign cmd_data = cd_ff;
	assign frame_err = fe_ff;
endmodule : swh_device_end
`default_nettype wire

// ### sim/swh_link_sva.sv
// Purpose: wire-level checks on the shared single-wire link
// Assumes: one clk_sys domain, rstn synchronous active low
// Notes: frame counters start on each party's own pull-down
`timescale 1ns/1ps
`default_nettype none
`include "swh_params.svh"
module swh_link_sva (
	input wire logic clk_sys, // system clock
	input wire logic rstn, // synchronous reset, active low
	input wire logic dev_line_oe, // device pull-down
	input wire logic host_line_oe, // host pull-down
	input wire logic line_level // resolved wire
);
	localparam int BIT_CYC = `SWH_TICK_DIV * `SWH_TICKS_PER_BIT;
	localparam int FRAME_CYC = BIT_CYC * `SWH_FRAME_BITS;
	localparam int STOP_CYC = BIT_CYC * (`SWH_FRAME_BITS - 1);
	logic [15:0] dev_cnt_ff, nxt_dev_cnt, host_cnt_ff, nxt_host_cnt;
	logic dev_prev_ff, host_prev_ff;
	// ----------------------------------------
	// frame position counters
	// ----------------------------------------
	// zero means no own frame on the wire; a frame counts up to one less than its length
	always_comb begin
		nxt_dev_cnt = 16'h0000;
		nxt_host_cnt = 16'h0000;
		if (dev_cnt_ff != 16'h0000) begin
			nxt_dev_cnt = (32'(dev_cnt_ff) == FRAME_CYC - 1) ? 16'h0000 : dev_cnt_ff + 16'h0001;
		end else if (dev_line_oe && !dev_prev_ff) begin
			nxt_dev_cnt = 16'h0001;
		end
		if (host_cnt_ff != 16'h0000) begin
			nxt_host_cnt = (32'(host_cnt_ff) == FRAME_CYC - 1) ? 16'h0000 : host_cnt_ff + 16'h0001;
		end else if (host_line_oe && !host_prev_ff) begin
			nxt_host_cnt = 16'h0001;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			dev_cnt_ff <= 16'h0000;
			host_cnt_ff <= 16'h0000;
			dev_prev_ff <= 1'b0;
			host_prev_ff <= 1'b0;
		end else begin
			dev_cnt_ff <= nxt_dev_cnt;
			host_cnt_ff <= nxt_host_cnt;
			dev_prev_ff <= dev_line_oe;
			host_prev_ff <= host_line_oe;
		end
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence s_dev_launch;
		dev_line_oe && !dev_prev_ff && dev_cnt_ff == 16'h0000;
	endsequence
	sequence s_host_launch;
		host_line_oe && !host_prev_ff && host_cnt_ff == 16'h0000;
	endsequence
	dev_start_bit_a: assert property ((dev_cnt_ff != 0 && dev_cnt_ff < BIT_CYC) |-> dev_line_oe)
		else $error("device start bit cut short");
	host_start_bit_a: assert property ((host_cnt_ff != 0 && host_cnt_ff < BIT_CYC) |-> host_line_oe)
		else $error("host start bit cut short");
	dev_stop_bit_a: assert property ((dev_cnt_ff >= STOP_CYC) |-> !dev_line_oe)
		else $error("device stop bit driven low");
	host_stop_bit_a: assert property ((host_cnt_ff >= STOP_CYC) |-> !host_line_oe)
		else $error("host stop bit driven low");
	dev_bit_time_a: assert property ((dev_cnt_ff % BIT_CYC != 0) |-> $stable(dev_line_oe))
		else $error("device bit changed inside a bit period");
	host_bit_time_a: assert property ((host_cnt_ff % BIT_CYC != 0) |-> $stable(host_line_oe))
		else $error("host bit changed inside a bit period");
	dev_idle_rel_a: assert property (dev_line_oe |-> (dev_cnt_ff != 0 || !dev_prev_ff))
		else $error("device pulls line outside a frame");
	host_idle_rel_a: assert property (host_line_oe |-> (host_cnt_ff != 0 || !host_prev_ff))
		else $error("host pulls line outside a frame");
	dev_launch_clear_a: assert property (s_dev_launch |-> host_cnt_ff == 0 && $past(line_level))
		else $error("device started during a host frame");
	host_launch_clear_a: assert property (s_host_launch |-> dev_cnt_ff == 0 && $past(line_level))
		else $error("host started during a device frame");
endmodule : swh_link_sva
`default_nettype wire

// ### sim/single_wire_host_uart_port_tb_top.sv
// Purpose: host command and device reply across the shared wire
// Assumes: 50 MHz clk_sys, both ends joined by swh_link_if
// Notes: one frame is 52000 cycles, so the run holds two frames
`timescale 1ns/1ps
`default_nettype none
`include "swh_params.svh"
module single_wire_host_uart_port_tb_top;
	localparam int BIT_CYC = `SWH_TICK_DIV * `SWH_TICKS_PER_BIT;
	logic clk_sys, rstn, tx_valid, chip_en, status_event, mode_req;
	logic [7:0] tx_data, status_msg, rx_data, cmd_byte, cmd_data, last_rx, cmd, got, exp;
	logic [31:0] two_byte_map, supported_map;
	logic tx_ready, tx_collision, rx_valid, mode_go, cmd_valid, frame_err;
	int n_mismatch, num_checks, n_cmd, n_rx, n_err, n_col;
	swh_link_if link ();
	swh_host_end swh_host_end_inst (.clk_sys(clk_sys), .rstn(rstn), .link(link.host), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .tx_collision(tx_collision), .rx_valid(rx_valid), .rx_data(rx_data));
	swh_device_end #(.DATA_TMO_CYC(60000)) swh_device_end_inst (.clk_sys(clk_sys), .rstn(rstn), .link(link.dev),
		.chip_en(chip_en), .two_byte_map(two_byte_map), .supported_map(supported_map), .status_event(status_event),
		.status_msg(status_msg), .mode_req(mode_req), .mode_go(mode_go), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
		.cmd_data(cmd_data), .frame_err(frame_err));
	swh_link_sva swh_link_sva_inst (.clk_sys(clk_sys), .rstn(rstn), .dev_line_oe(link.dev_line_oe),
		.host_line_oe(link.host_line_oe), .line_level(link.line_level));
	// ----------------------------------------
	// clock and event monitors
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// pulses last one cycle; counted at the falling edge, where they are settled
	always @(negedge clk_sys) begin
		if (rstn && cmd_valid) n_cmd++;
		if (rstn && tx_collision) n_col++;
		if (rstn && frame_err) n_err++;
		if (rstn && rx_valid) begin
			n_rx++;
			last_rx = rx_data;
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] exp_rsp(input logic [7:0] c, input logic [31:0] sup);
		logic ok;
		ok = c[7] && c[6:5] == 2'b00 && sup[c[4:0]];
		return {1'b0, ok, c[5:0]};
	endfunction : exp_rsp
	task automatic check(input logic [7:0] g, input logic [7:0] e, input string what);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, g, e);
		end
	endtask : check
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude
	// bounded wait for a start edge on the wire
	task automatic wait_low(input int bound);
		int i;
		i = 0;
		while (link.line_level !== 1'b0 && i < bound) begin
			@(negedge clk_sys);
			i++;
		end
		if (i >= bound) begin
			n_mismatch++;
			$display("wrong value at %0t: line never fell", $time);
			conclude();
		end
	endtask : wait_low
	// samples bit centres on the wire itself, independent of both receivers
	task automatic watch_frame(output logic [7:0] b, input int bound);
		wait_low(bound);
		// request held until the host has taken it and pulled the wire
		tx_valid = 1'b0;
		repeat (BIT_CYC / 2) @(negedge clk_sys);
		check({7'h00, link.line_level}, 8'h00, "start bit");
		check({7'h00, mode_go}, 8'h00, "mode change during frame");
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(negedge clk_sys);
			b[i] = link.line_level;
		end
		repeat (BIT_CYC) @(negedge clk_sys);
		check({7'h00, link.line_level}, 8'h01, "stop bit");
	endtask : watch_frame
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rstn, tx_valid, chip_en, status_event, mode_req} = 5'h00;
		{tx_data, status_msg, two_byte_map, supported_map} = '0;
		{n_mismatch, num_checks, n_cmd, n_rx, n_err, n_col} = '0;
		void'($urandom(32'h0000_1f80));
		repeat (5) @(negedge clk_sys);
		rstn = 1'b1;
		repeat (2) @(negedge clk_sys);
		check({7'h00, link.line_level}, 8'h01, "idle level");
		check({7'h00, tx_ready}, 8'h01, "sender ready");
		$display("test idle done");
		// chip_en stays low: the status event must not start a frame
		supported_map = $urandom();
		cmd = {3'b100, 5'($urandom())};
		status_msg = 8'($urandom());
		status_event = 1'b1;
		tx_data = cmd;
		tx_valid = 1'b1;
		@(negedge clk_sys);
		status_event = 1'b0;
		mode_req = 1'b1;
		watch_frame(got, BIT_CYC);
		check(got, cmd, "host frame bits");
		exp = exp_rsp(cmd, supported_map);
		watch_frame(got, `SWH_MAX_RSP_CYC);
		check(got, exp, "reply byte");
		repeat (BIT_CYC / 2 + 8) @(negedge clk_sys);
		check(last_rx, exp, "host received reply");
		check(8'(n_col), 8'h00, "no contention seen");
		check(cmd_data, 8'h00, "no data byte");
		check(8'(n_rx), 8'h01, "reply count");
		check(8'(n_cmd), {7'h00, exp[6]}, "command accepted");
		if (exp[6]) check(cmd_byte, cmd, "command byte");
		check(8'(n_err), 8'h00, "no framing error");
		check({7'h00, link.line_level}, 8'h01, "no unsolicited frame");
		check({7'h00, mode_go}, 8'h01, "mode change after message");
		$display("test command %h done", cmd);
		conclude();
	end
endmodule : single_wire_host_uart_port_tb_top
`default_nettype wire
